// File: verilog/asr_pkg.sv
package asr_pkg;
  // ----------------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------------
  localparam int RESULT_BITS   = 14;
  localparam int GAP_CYCLES    = 2;
  localparam int SLOT_CYCLES   = RESULT_BITS + GAP_CYCLES;
  localparam int MAX_CHANNELS  = 6;
  localparam int LOCKOUT_EDGES = SLOT_CYCLES * MAX_CHANNELS;
  localparam int SEL_BITS      = 3;
  localparam int START_DELAY   = 3;
  localparam int FIFO_DEPTH    = 32;

  localparam logic [SEL_BITS-1:0] SEL_ALL = 3'h0;
  localparam logic [SEL_BITS-1:0] SEL_MAX = 3'h6;

  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_LEAD,
    ASR_GAP,
    ASR_DATA
  } asr_state_e;
endpackage

// File: verilog/asr_sync.sv
module asr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // System clock.
  input  wire logic             rst_n,  // Synchronous reset, active low.
  input  wire logic             en,     // Clock enable.
  input  wire logic [WIDTH-1:0] d,      // Asynchronous input.
  output logic      [WIDTH-1:0] q       // Synchronised output.
);
  logic [WIDTH-1:0] stage1_reg;

  // The first stage feeds only the second one.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      q          <= '0;
    end else if (en) begin
      stage1_reg <= d;
      q          <= stage1_reg;
    end
  end
endmodule

// File: verilog/asr_fifo.sv
module asr_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,      // System clock.
  input  wire logic             rst_n,    // Synchronous reset, active low.
  input  wire logic             en,       // Clock enable.
  input  wire logic [WIDTH-1:0] inData,   // Write word.
  input  wire logic             inValid,  // Write request.
  output logic                  inReady,  // Space available.
  output logic      [WIDTH-1:0] outData,  // Head word.
  output logic                  outValid, // Head word present.
  input  wire logic             outReady  // Reader takes head.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] memArr [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      countNext;
  logic             doWr;
  logic             doRd;

  always_comb begin
    countNext = count_reg;
    if (doWr && !doRd) begin
      countNext = count_reg + 1'b1;
    end else if (doRd && !doWr) begin
      countNext = count_reg - 1'b1;
    end
  end

  assign outValid = (count_reg != '0);
  assign outData  = memArr[rdPtr_reg];
  assign doWr     = en && inValid && inReady;
  assign doRd     = en && outValid && outReady;

  always_ff @(posedge clk) begin
    if (doWr) begin
      memArr[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady   <= 1'b1;
    end else begin
      count_reg <= countNext;
      // Registered so that ready leaves the block from a flip-flop; it
      // always equals the not-full test on the count beside it.
      inReady   <= (countNext != (AW+1)'(DEPTH));
      if (doWr) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRd) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
    end
  end
endmodule

// File: verilog/asr_readout.sv
// Behaviour
// - Serial result output is high impedance after reset, no command needed.
// - Output stays high impedance until a conversion-start rising edge.
// - Data starts after third serial clock rise; up to six 14-bit results.
// - Results are separated by two high-impedance serial clock cycles.
// - Each bit is valid by the next serial clock rising edge.
// - Frame length is 16 to 96 bits depending on channel count.
// - Further start edges are ignored until 96 serial clock rises.
// - Each serial clock rise advances and updates output; MSB first.
module asr_readout #(
  parameter int RESULT_BITS = asr_pkg::RESULT_BITS,
  parameter int FIFO_DEPTH  = asr_pkg::FIFO_DEPTH
) (
  input  wire logic                   clk,                  // 100 MHz clock.
  input  wire logic                   rst_n,                // Sync reset.
  input  wire logic                   clkEn,                // Clock enable.
  input  wire logic                   conversionStartIn,    // Start pin.
  input  wire logic                   hostReceiveClockIn,   // Serial clock.
  input  wire logic [asr_pkg::SEL_BITS-1:0] channelCountSelect, // Channels.
  input  wire logic [RESULT_BITS-1:0] resultData,           // Core result.
  input  wire logic                   resultValid,          // Result offer.
  output logic                        resultReady,          // Result taken.
  output logic                        serialResultOut,      // Data level.
  output logic                        serialResultOutEn,    // Drive enable.
  output logic                        frameActive,          // Frame running.
  output logic                        overrun               // Result missing.
);
  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  // The start, clock and select pins come from the host's domain, so they
  // are resampled here and
  // edges are found on the synchronised copies. This limits the serial
  // clock to well below a quarter of the system clock.
  logic [asr_pkg::SEL_BITS+1:0] pinSync;
  logic [asr_pkg::SEL_BITS-1:0] selSync;
  logic                         convPrev_reg;
  logic                         sckPrev_reg;
  logic                         convRise;
  logic                         sckRise;

  asr_sync #(
    .WIDTH (asr_pkg::SEL_BITS + 2)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (clkEn),
    .d     ({channelCountSelect, conversionStartIn, hostReceiveClockIn}),
    .q     (pinSync)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      convPrev_reg <= 1'b0;
      sckPrev_reg  <= 1'b0;
    end else if (clkEn) begin
      convPrev_reg <= pinSync[1];
      sckPrev_reg  <= pinSync[0];
    end
  end

  assign convRise = pinSync[1] && !convPrev_reg;
  assign sckRise  = pinSync[0] && !sckPrev_reg;
  assign selSync  = pinSync[asr_pkg::SEL_BITS+1:2];

  // ----------------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------------
  logic [RESULT_BITS-1:0] fifoData;
  logic                   fifoValid;
  logic                   fifoPop;

  asr_fifo #(
    .WIDTH (RESULT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .en       (clkEn),
    .inData   (resultData),
    .inValid  (resultValid),
    .inReady  (resultReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  asr_pkg::asr_state_e    state_reg;
  logic [6:0]             lockout_reg;
  logic [4:0]             bitCnt_reg;
  logic [2:0]             slotsLeft_reg;
  logic [RESULT_BITS-1:0] shift_reg;
  logic [2:0]             slotsWanted;
  logic                   startTaken;
  logic                   slotLoad;

  // Code zero or any code past six asks for the full six-channel frame.
  always_comb begin
    if (selSync == asr_pkg::SEL_ALL ||
        selSync > asr_pkg::SEL_MAX) begin
      slotsWanted = 3'(asr_pkg::MAX_CHANNELS);
    end else begin
      slotsWanted = selSync;
    end
  end

  assign startTaken = convRise && (lockout_reg == '0);
  // The word for a slot leaves the buffer at the last gap edge, so a late
  // result only costs that one slot and is flagged.
  assign slotLoad   = sckRise && (state_reg == asr_pkg::ASR_GAP) &&
                      (bitCnt_reg == 5'(asr_pkg::GAP_CYCLES - 1));
  assign fifoPop    = slotLoad && fifoValid;

  // Lockout counts serial clock rises after an accepted start.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockout_reg <= '0;
    end else if (clkEn) begin
      if (startTaken) begin
        lockout_reg <= 7'(asr_pkg::LOCKOUT_EDGES);
      end else if (sckRise && lockout_reg != '0) begin
        lockout_reg <= lockout_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= asr_pkg::ASR_IDLE;
      bitCnt_reg    <= '0;
      slotsLeft_reg <= '0;
    end else if (clkEn) begin
      if (startTaken) begin
        state_reg     <= asr_pkg::ASR_LEAD;
        bitCnt_reg    <= '0;
        slotsLeft_reg <= slotsWanted;
      end else if (sckRise) begin
        unique case (state_reg)
          asr_pkg::ASR_IDLE: begin
            bitCnt_reg <= '0;
          end
          // The first two rises are the gap of slot one; data on the third.
          asr_pkg::ASR_LEAD: begin
            state_reg  <= asr_pkg::ASR_GAP;
            bitCnt_reg <= '0;
          end
          asr_pkg::ASR_GAP: begin
            if (bitCnt_reg == 5'(asr_pkg::GAP_CYCLES - 1)) begin
              state_reg  <= asr_pkg::ASR_DATA;
              bitCnt_reg <= '0;
            end else begin
              bitCnt_reg <= bitCnt_reg + 1'b1;
            end
          end
          asr_pkg::ASR_DATA: begin
            if (bitCnt_reg == 5'(RESULT_BITS - 1)) begin
              bitCnt_reg <= '0;
              if (slotsLeft_reg == 3'h1) begin
                state_reg     <= asr_pkg::ASR_IDLE;
                slotsLeft_reg <= '0;
              end else begin
                state_reg     <= asr_pkg::ASR_GAP;
                slotsLeft_reg <= slotsLeft_reg - 1'b1;
              end
            end else begin
              bitCnt_reg <= bitCnt_reg + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (clkEn && sckRise) begin
      if (slotLoad) begin
        shift_reg <= fifoValid ? fifoData : '0;
      end else if (state_reg == asr_pkg::ASR_DATA) begin
        shift_reg <= {shift_reg[RESULT_BITS-2:0], 1'b0};
      end
    end
  end

  // Pin level and enable follow the state one system clock after the edge,
  // far inside one serial clock period.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serialResultOut   <= 1'b0;
      serialResultOutEn <= 1'b0;
      frameActive       <= 1'b0;
      overrun           <= 1'b0;
    end else if (clkEn) begin
      serialResultOut   <= (state_reg == asr_pkg::ASR_DATA) &&
                           shift_reg[RESULT_BITS-1];
      serialResultOutEn <= (state_reg == asr_pkg::ASR_DATA);
      frameActive       <= (state_reg != asr_pkg::ASR_IDLE);
      overrun           <= slotLoad && !fifoValid;
    end
  end
endmodule

// File: dv/asr_readout_assertions.sv
module asr_readout_checker #(
  parameter int RESULT_BITS = asr_pkg::RESULT_BITS,
  parameter int FIFO_DEPTH  = asr_pkg::FIFO_DEPTH,
  parameter int SEL_BITS    = asr_pkg::SEL_BITS
) (
  input wire logic                   clk,                // Clock.
  input wire logic                   rst_n,              // Reset.
  input wire logic                   clkEn,              // Enable.
  input wire logic                   conversionStartIn,  // Start pin.
  input wire logic                   hostReceiveClockIn, // Serial clock.
  input wire logic [SEL_BITS-1:0]    channelCountSelect, // Channels.
  input wire logic [RESULT_BITS-1:0] resultData,         // Result.
  input wire logic                   resultValid,        // Offer.
  input wire logic                   resultReady,        // Space.
  input wire logic                   serialResultOut,    // Data.
  input wire logic                   serialResultOutEn,  // Drive.
  input wire logic                   frameActive,        // Frame.
  input wire logic                   overrun             // Empty slot.
);
  logic       sckPrev;
  logic       convPrev;
  logic       sckRise;
  logic       convRise;
  logic [4:0] dataRises;
  logic [2:0] gapRises;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  assign sckRise  = hostReceiveClockIn && !sckPrev;
  assign convRise = conversionStartIn && !convPrev;
  always_ff @(posedge clk) begin
    sckPrev  <= hostReceiveClockIn;
    convPrev <= conversionStartIn;
  end
  always_ff @(posedge clk) begin
    if (!serialResultOutEn) dataRises <= 5'h00;
    else if (sckRise) dataRises <= dataRises + 5'h01;
  end
  // Starting at minus one lets the lead-in and later gaps share one figure.
  always_ff @(posedge clk) begin
    if (serialResultOutEn) gapRises <= 3'h0;
    else if (convRise) gapRises <= 3'h7;
    else if (sckRise) gapRises <= gapRises + 3'h1;
  end
  a_reset_quiet:
    assert property ($rose(rst_n) |-> !serialResultOutEn && !frameActive)
    else $error("line driven after reset");
  a_drive_in_frame:
    assert property (serialResultOutEn |-> frameActive || $past(frameActive))
    else $error("line driven outside a frame");
  a_drive_on_rise:
    assert property ($changed(serialResultOut) || $changed(serialResultOutEn)
      |-> $past(hostReceiveClockIn, 3) && !$past(hostReceiveClockIn, 6))
    else $error("line changed away from a clock rise");
  a_gap_two_rises:
    assert property ($rose(serialResultOutEn) |-> gapRises == 3'h2)
    else $error("wrong gap before a word");
  a_word_bits:
    assert property ($fell(serialResultOutEn) |-> dataRises == 5'h0e)
    else $error("word not fourteen bits long");
  a_undriven_low:
    assert property (!serialResultOutEn |-> !serialResultOut)
    else $error("level high while released");
  a_overrun_pulse:
    assert property (overrun |=> !overrun)
    else $error("overrun longer than one cycle");
  a_full_on_write:
    assert property ($fell(resultReady) |-> $past(resultValid && resultReady))
    else $error("buffer filled without a write");
endmodule

bind asr_readout asr_readout_checker #(
  .RESULT_BITS(RESULT_BITS), .FIFO_DEPTH(FIFO_DEPTH)
) i_asr_readout_checker (
  .clk(clk), .rst_n(rst_n), .clkEn(clkEn),
  .conversionStartIn(conversionStartIn),
  .hostReceiveClockIn(hostReceiveClockIn),
  .channelCountSelect(channelCountSelect), .resultData(resultData),
  .resultValid(resultValid), .resultReady(resultReady),
  .serialResultOut(serialResultOut),
  .serialResultOutEn(serialResultOutEn), .frameActive(frameActive),
  .overrun(overrun)
);

// File: dv/asr_host_model.sv
module asr_host_model (
  input  wire logic clk,   // Bench clock.
  input  wire logic serial_result_out,   // Data level.
  input  wire logic sdoEn, // Line driven.
  output logic      sck,   // Serial clock.
  output logic      conversion_start_in   // Frame start.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        lastLvl = 1'b0;
  logic        lineLvl;
  logic [15:0] word;
  logic        en[$];
  // One 1024-word ring, filled in order as a receive port
  // would; the bench reads back the words of the latest frame.
  logic [15:0] ring[1024];
  int          wrIdx = 0;
  int          frameBase;
  // The line has no pull, so a released line shows the opposite level.
  assign lineLvl = sdoEn ? serial_result_out : ~lastLvl;
  always_ff @(posedge clk) if (sdoEn) lastLvl <= serial_result_out;
  initial begin
    sck = 1'b0;
    conversion_start_in = 1'b0;
  end
  function automatic logic [15:0] got(input int w);
    return ring[(frameBase + w) % 1024];
  endfunction
  task automatic frame(input int n, input int again);
    en.delete();
    frameBase = wrIdx;
    word = '0;
    @(posedge clk);
    #1 conversion_start_in = 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 1; k <= n; k++) begin
      #1 sck = 1'b1;
      conversion_start_in = (k == again);
      repeat (5) @(posedge clk);
      #1 word = {word[14:0], lineLvl};
      en.push_back(sdoEn);
      if (k % 16 == 0) begin
        ring[wrIdx] = word & 16'h3fff;
        wrIdx = (wrIdx + 1) % 1024;
      end
      sck = 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// File: dv/test_asr_readout.sv
module test_asr_readout;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, clkEn, conversion_start_in, sck, valid, ready;
  logic        serial_result_out, sdoEn, active, overrun;
  logic [2:0]  sel;
  logic [13:0] data;
  logic [15:0] lfsr;
  logic [13:0] expQ[$];
  int          num_errors, checks_done, cycles, ovSeen;
  int          sels[8]   = '{6, 0, 7, 1, 2, 3, 4, 5};
  int          agains[8] = '{0, 40, 0, 20, 0, 0, 0, 0};
  asr_readout i_asr_readout (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .conversionStartIn(conversion_start_in),
    .hostReceiveClockIn(sck), .channelCountSelect(sel), .resultData(data),
    .resultValid(valid), .resultReady(ready), .serialResultOut(serial_result_out),
    .serialResultOutEn(sdoEn), .frameActive(active), .overrun(overrun)
  );
  asr_host_model i_asr_host_model (
    .clk(clk), .serial_result_out(serial_result_out), .sdoEn(sdoEn), .sck(sck), .conversion_start_in(conversion_start_in)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (overrun === 1'b1) ovSeen++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  function automatic logic [13:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[13:0];
  endfunction
  task automatic cmp(string what, logic [15:0] e, logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask
  task automatic run(int n, int again);
    int          nCh;
    logic [15:0] e;
    nCh = (n == 0 || n > 6) ? 6 : n;
    @(posedge clk);
    #1 sel = 3'(n);
    i_asr_host_model.frame(100, again);
    #1 cmp("active", 16'h0000, 16'(active));
    for (int k = 0; k < 100; k++) begin
      e = 16'(k < 16 * nCh && k % 16 >= 2);
      cmp("drive", e, 16'(i_asr_host_model.en[k]));
    end
    for (int w = 0; w < nCh; w++) begin
      e = expQ.size() > 0 ? {2'h0, expQ.pop_front()} : 16'h0000;
      cmp("word", e, i_asr_host_model.got(w));
    end
    $display("frame of %0d channels done", nCh);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    valid = 1'b0;
    data = '0;
    sel = '0;
    lfsr = 16'h1bba;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp("drive", 16'h0000, 16'(sdoEn));
    // Writes offered while the enable is low must not reach the buffer.
    clkEn = 1'b0;
    valid = 1'b1;
    data = 14'h2aaa;
    repeat (4) @(posedge clk);
    #1 clkEn = 1'b1;
    for (int i = 0; i < 33; i++) begin
      data = i == 0 ? 14'h3fff : i == 1 ? 14'h0001 : rnd();
      cmp("ready", 16'(i < 32), 16'(ready));
      if (i < 32) expQ.push_back(data);
      @(posedge clk);
      #1;
    end
    valid = 1'b0;
    cmp("drive", 16'h0000, 16'(sdoEn));
    $display("buffer fill done");
    foreach (sels[j]) run(sels[j], agains[j]);
    cmp("overrun", 16'h0001, 16'(ovSeen));
    test_done();
  end
endmodule
